// [verilog/csb_pkg.sv]
package csb_pkg;
   localparam logic [5:0] ADDR_INDIRECT = 6'h00;
   localparam logic [5:0] ADDR_PCL = 6'h02;
   localparam logic [5:0] ADDR_STATUS = 6'h03;
   localparam logic [5:0] ADDR_FSP = 6'h04;
   localparam logic [5:0] ADDR_PORT = 6'h06;
   localparam logic [5:0] ADDR_PWR = 6'h08;
   localparam logic [5:0] ADDR_WAKE = 6'h09;
   localparam logic [5:0] ADDR_PCHB = 6'h0a;
   localparam logic [5:0] ADDR_PLOW = 6'h0b;
   localparam logic [5:0] ADDR_PHIGH = 6'h0c;
   localparam int ST_CARRY = 0;
   localparam int ST_HALF = 1;
   localparam int ST_ZERO = 2;
   localparam int ST_PD = 3;
   localparam int ST_TO = 4;
   localparam int PWR_WDT = 7;
   localparam int PWR_EIS = 6;
   localparam int PWR_LVR = 3;
   localparam logic [7:0] RST_PCL = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h18;
   localparam logic [7:0] RST_FSP = 8'h00;
   localparam logic [7:0] RST_PWR = 8'h88;
   localparam logic [7:0] RST_WAKE = 8'h3f;
   localparam logic [7:0] MASK_WAKE = 8'h3f;
   localparam logic [7:0] RST_PCHB = 8'h00;
   localparam logic [7:0] MASK_PCHB = 8'h07;
   localparam logic [7:0] RST_PLOW = 8'hff;
   localparam logic [7:0] MASK_PLOW = 8'hf0;
   localparam logic [7:0] RST_PHIGH = 8'h3f;
   localparam logic [7:0] MASK_PHIGH = 8'h3f;
   localparam logic [7:0] RST_PORT = 8'h00;

   typedef enum logic [2:0] {
      CSB_PC_STEP,
      CSB_PC_HOLD,
      CSB_PC_JUMP,
      CSB_PC_CALL,
      CSB_PC_LJUMP,
      CSB_PC_LONG_CALL
   } csb_pcop_e;

   typedef struct packed {
      logic [1:0] pcHigh;
      logic [7:0] pcLow;
      logic [7:0] status;
      logic [7:0] fileSel;
      logic [7:0] portLatch;
      logic [7:0] power;
      logic [7:0] wake;
      logic [7:0] pcHighBuf;
      logic [7:0] pullLow;
      logic [7:0] pullHigh;
      logic [7:0] rdData;
      logic [9:0] pushAddr;
      logic push;
   } csb_state_s;

   typedef struct packed {
      logic carryValid;
      logic carry;
      logic halfValid;
      logic half;
      logic zeroValid;
      logic zero;
   } csb_flags_s;
endpackage

// [verilog/csb_core_sfr.sv]
// Operation
// - Low program counter byte is read/write and steps after each ordinary instruction.
// - Upper counter bits change only on jumps and calls, from the high buffer and/or the instruction.
// - Short jump takes bits 8..0 from instruction, bit 9 from buffer bit 1.
// - Short call takes bits 7..0 from instruction, 9..8 from buffer, pushes next address.
// - Long jump loads all ten counter bits from instruction, buffer ignored.
// - Long call loads all ten bits from instruction and pushes next address.
// - Carry flag in status bit 0 follows add carry or subtract no-borrow.
// - Half-carry flag follows carry out of low nibble or no nibble borrow.
// - Zero flag in status bit 2 is set when logical result is zero.
// - Power-down flag low on sleep, high at power-up and watchdog clear.
// - Timeout flag high at power-up, watchdog clear or sleep; low on timeout.
// - Status bits 7..5 are plain storage resetting to zero.
// - Low six pointer bits select one of sixty-four data locations.
// - Pointer bank bits have no addressing effect and reset to zero.
// - Port read gives pin for inputs; outputs give pin or latch per option.
// - Port write stores into output latch; bits 7..6 are plain storage.
// - Power control bits enable watchdog, pin-zero interrupt and low-voltage reset.
// - Wake-up enables for pins 5..0 in bits 5..0, reset to one.
// - Active-low pull-low enables for pins 3..0 in bits 7..4, reset one.
// - Active-low pull-high enables for pins 5,4,2,1,0; bit 3 storage.
// - Port bits 7 and 6 are storage independent of any pin.
// - Indirect location accesses go to the location named by the pointer.
`timescale 1ns/100ps
module csb_core_sfr
   import csb_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [5:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWrData,
   input wire csb_pcop_e pcOp,
   input wire logic [9:0] instTarget,
   input wire csb_flags_s aluFlags,
   input wire logic sleepExec,
   input wire logic clearWatchdogExec,
   input wire logic watchdogTimeout,
   input wire logic [5:0] portPins,
   input wire logic [5:0] portDirIn,
   input wire logic portReadbackOption,
   input wire logic [7:0] dataMemRdData,
   output logic [7:0] regRdData,
   output logic [9:0] programCounter,
   output logic [5:0] dataMemAddr,
   output logic [9:0] returnAddr,
   output logic returnPush,
   output logic [7:0] portLatch,
   output logic watchdogEnable,
   output logic extIrqPinSelect,
   output logic lowVoltageResetEnable,
   output logic [5:0] pinWakeupEnable,
   output logic [3:0] pullLowEnable_n,
   output logic [5:0] pullHighEnable_n
);
   csb_state_s cur_ff;
   csb_state_s nxt_cur;
   logic [5:0] pinSync1_ff;
   logic [5:0] pinSync2_ff;
   logic [5:0] nxt_pinSync1;
   logic [5:0] nxt_pinSync2;
   logic [5:0] effAddr;
   logic [9:0] pcNow;
   logic [9:0] pcNext;
   logic [7:0] portView;

   assign pcNow = {cur_ff.pcHigh, cur_ff.pcLow};
   assign pcNext = 10'(pcNow + 10'h001);
   assign nxt_pinSync1 = portPins;
   assign nxt_pinSync2 = pinSync1_ff;

   // Indirect accesses resolve through the pointer, bank bits unused.
   assign effAddr = (regAddr == ADDR_INDIRECT) ? cur_ff.fileSel[5:0] : regAddr;

   always_comb begin
      for (int i = 0; i < 6; i++) begin
         portView[i] = (portDirIn[i] || !portReadbackOption) ? pinSync2_ff[i]
                                                          : cur_ff.portLatch[i];
      end
      portView[7:6] = cur_ff.portLatch[7:6];
   end

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.push = 1'b0;
      // Counter update comes first; a write to the low byte overrides stepping.
      unique case (pcOp)
         CSB_PC_STEP: nxt_cur.pcLow = pcNext[7:0];
         CSB_PC_HOLD: nxt_cur.pcLow = cur_ff.pcLow;
         CSB_PC_JUMP: {nxt_cur.pcHigh, nxt_cur.pcLow} =
            {cur_ff.pcHighBuf[1], instTarget[8:0]};
         CSB_PC_CALL: {nxt_cur.pcHigh, nxt_cur.pcLow} =
            {cur_ff.pcHighBuf[1:0], instTarget[7:0]};
         CSB_PC_LJUMP: {nxt_cur.pcHigh, nxt_cur.pcLow} = instTarget;
         CSB_PC_LONG_CALL: {nxt_cur.pcHigh, nxt_cur.pcLow} = instTarget;
         default: nxt_cur.pcLow = cur_ff.pcLow;
      endcase
      if (pcOp == CSB_PC_STEP && pcNow == 10'h0ff) begin
         nxt_cur.pcHigh = cur_ff.pcHigh;
      end
      if (pcOp == CSB_PC_CALL || pcOp == CSB_PC_LONG_CALL) begin
         nxt_cur.push = 1'b1;
         nxt_cur.pushAddr = pcNext;
      end
      if (aluFlags.carryValid) nxt_cur.status[ST_CARRY] = aluFlags.carry;
      if (aluFlags.halfValid) nxt_cur.status[ST_HALF] = aluFlags.half;
      if (aluFlags.zeroValid) nxt_cur.status[ST_ZERO] = aluFlags.zero;
      if (regWrite) begin
         unique case (effAddr)
            ADDR_PCL: nxt_cur.pcLow = regWrData;
            ADDR_STATUS: nxt_cur.status = regWrData;
            ADDR_FSP: nxt_cur.fileSel = regWrData;
            ADDR_PORT: nxt_cur.portLatch = regWrData;
            ADDR_PWR: nxt_cur.power = regWrData;
            ADDR_WAKE: nxt_cur.wake = regWrData & MASK_WAKE;
            ADDR_PCHB: nxt_cur.pcHighBuf = regWrData & MASK_PCHB;
            ADDR_PLOW: nxt_cur.pullLow = (regWrData & MASK_PLOW) | ~MASK_PLOW;
            ADDR_PHIGH: nxt_cur.pullHigh = regWrData & MASK_PHIGH;
            default: nxt_cur.status = nxt_cur.status;
         endcase
      end
      // Hardware events win over software writes of the reset-cause flags.
      if (clearWatchdogExec) begin
         nxt_cur.status[ST_PD] = 1'b1;
         nxt_cur.status[ST_TO] = 1'b1;
      end
      if (sleepExec) begin
         nxt_cur.status[ST_PD] = 1'b0;
         nxt_cur.status[ST_TO] = 1'b1;
      end
      if (watchdogTimeout) nxt_cur.status[ST_TO] = 1'b0;
      nxt_cur.rdData = 8'h00;
      if (regRead) begin
         unique case (effAddr)
            ADDR_PCL: nxt_cur.rdData = cur_ff.pcLow;
            ADDR_STATUS: nxt_cur.rdData = cur_ff.status;
            ADDR_FSP: nxt_cur.rdData = cur_ff.fileSel;
            ADDR_PORT: nxt_cur.rdData = portView;
            ADDR_PWR: nxt_cur.rdData = cur_ff.power;
            ADDR_WAKE: nxt_cur.rdData = cur_ff.wake;
            ADDR_PCHB: nxt_cur.rdData = cur_ff.pcHighBuf;
            ADDR_PLOW: nxt_cur.rdData = cur_ff.pullLow;
            ADDR_PHIGH: nxt_cur.rdData = cur_ff.pullHigh;
            default: nxt_cur.rdData = dataMemRdData;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      pinSync1_ff <= nxt_pinSync1;
      pinSync2_ff <= nxt_pinSync2;
      if (reset) begin
         cur_ff <= '0;
         cur_ff.pcLow <= RST_PCL;
         cur_ff.status <= RST_STATUS;
         cur_ff.fileSel <= RST_FSP;
         cur_ff.portLatch <= RST_PORT;
         cur_ff.power <= RST_PWR;
         cur_ff.wake <= RST_WAKE;
         cur_ff.pcHighBuf <= RST_PCHB;
         cur_ff.pullLow <= RST_PLOW;
         cur_ff.pullHigh <= RST_PHIGH;
         dataMemAddr <= 6'h00;
      end else begin
         cur_ff <= nxt_cur;
         dataMemAddr <= effAddr;
      end
   end

   always_ff @(posedge clock) begin
      regRdData <= nxt_cur.rdData;
      programCounter <= reset ? 10'h000 : {nxt_cur.pcHigh, nxt_cur.pcLow};
      returnAddr <= reset ? 10'h000 : nxt_cur.pushAddr;
      returnPush <= reset ? 1'b0 : nxt_cur.push;
      portLatch <= reset ? RST_PORT : nxt_cur.portLatch;
      watchdogEnable <= reset ? RST_PWR[PWR_WDT] : nxt_cur.power[PWR_WDT];
      extIrqPinSelect <= reset ? RST_PWR[PWR_EIS] : nxt_cur.power[PWR_EIS];
      lowVoltageResetEnable <= reset ? RST_PWR[PWR_LVR] : nxt_cur.power[PWR_LVR];
      pinWakeupEnable <= reset ? RST_WAKE[5:0] : nxt_cur.wake[5:0];
      pullLowEnable_n <= reset ? RST_PLOW[7:4] : nxt_cur.pullLow[7:4];
      // Pin 3 has no pull-high, so its enable stays off while bit 3 is storage.
      pullHighEnable_n <= reset ? {RST_PHIGH[5:4], 1'b1, RST_PHIGH[2:0]}
                                : {nxt_cur.pullHigh[5:4], 1'b1, nxt_cur.pullHigh[2:0]};
   end

   long_jump_a: assert property (@(posedge clock) disable iff (reset)
      pcOp == CSB_PC_LJUMP |=> cur_ff.pcHigh == $past(instTarget[9:8]))
      else $error("long jump upper bits wrong");
   short_jump_a: assert property (@(posedge clock) disable iff (reset)
      pcOp == CSB_PC_JUMP |=> cur_ff.pcHigh[1] == $past(cur_ff.pcHighBuf[1]))
      else $error("short jump bit 9 not from buffer");
   call_push_a: assert property (@(posedge clock) disable iff (reset)
      (pcOp == CSB_PC_CALL || pcOp == CSB_PC_LONG_CALL) |=> returnPush)
      else $error("call did not push");
   push_addr_a: assert property (@(posedge clock) disable iff (reset)
      (pcOp == CSB_PC_CALL || pcOp == CSB_PC_LONG_CALL) |=> returnAddr == $past(pcNext))
      else $error("pushed address wrong");
   pull_high_a: assert property (@(posedge clock) disable iff (reset)
      pullHighEnable_n[3] == 1'b1)
      else $error("pin three pull-high enabled");
   high_stable_a: assert property (@(posedge clock) disable iff (reset)
      (pcOp == CSB_PC_STEP || pcOp == CSB_PC_HOLD) |=> $stable(cur_ff.pcHigh))
      else $error("upper counter bits moved");
   sleep_flags_a: assert property (@(posedge clock) disable iff (reset)
      sleepExec && !watchdogTimeout |=> !cur_ff.status[ST_PD] && cur_ff.status[ST_TO])
      else $error("sleep flags wrong");
   timeout_flag_a: assert property (@(posedge clock) disable iff (reset)
      watchdogTimeout |=> !cur_ff.status[ST_TO])
      else $error("timeout flag not cleared");
   carry_flag_a: assert property (@(posedge clock) disable iff (reset)
      aluFlags.carryValid && !(regWrite && effAddr == ADDR_STATUS)
      |=> cur_ff.status[ST_CARRY] == $past(aluFlags.carry))
      else $error("carry flag wrong");
   wake_mask_a: assert property (@(posedge clock) disable iff (reset)
      cur_ff.wake[7:6] == 2'b00 && cur_ff.pullLow[3:0] == 4'hf)
      else $error("reserved bits changed");
endmodule

// [tb/csb_mem_model.sv]
`timescale 1ns/100ps
module csb_mem_model (
   input wire logic [5:0] memAddr,
   output logic [7:0] memRdData
);
   // General memory answers with a pattern that encodes the location read.
   assign memRdData = {2'b10, memAddr};
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
   import csb_pkg::*;
   logic clock, reset, regWrite, regRead, sleepExec, clearWatchdogExec, watchdogTimeout;
   logic portReadbackOption, returnPush, watchdogEnable, extIrqPinSelect, lowVoltageResetEnable;
   logic [5:0] regAddr, portPins, portDirIn, dataMemAddr, pinWakeupEnable, pullHighEnable_n;
   logic [7:0] regWrData, dataMemRdData, regRdData, portLatch;
   logic [9:0] instTarget, programCounter, returnAddr;
   logic [3:0] pullLowEnable_n;
   csb_pcop_e pcOp;
   csb_flags_s aluFlags;
   int num_errors = 0;
   int checked = 0;
   logic [5:0] ta [8] = '{6'h02, 6'h03, 6'h04, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c};
   logic [7:0] tr [8] = '{8'h00, 8'h18, 8'h00, 8'h88, 8'h3f, 8'h00, 8'hff, 8'h3f};
   logic [7:0] t1 [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h07, 8'hff, 8'h3f};
   logic [7:0] t0 [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00};

   csb_core_sfr csb_core_sfr_inst (.clock(clock), .reset(reset), .regAddr(regAddr),
      .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData), .pcOp(pcOp),
      .instTarget(instTarget), .aluFlags(aluFlags), .sleepExec(sleepExec),
      .clearWatchdogExec(clearWatchdogExec), .watchdogTimeout(watchdogTimeout),
      .portPins(portPins), .portDirIn(portDirIn), .portReadbackOption(portReadbackOption),
      .dataMemRdData(dataMemRdData), .regRdData(regRdData), .programCounter(programCounter),
      .dataMemAddr(dataMemAddr), .returnAddr(returnAddr), .returnPush(returnPush),
      .portLatch(portLatch), .watchdogEnable(watchdogEnable),
      .extIrqPinSelect(extIrqPinSelect), .lowVoltageResetEnable(lowVoltageResetEnable),
      .pinWakeupEnable(pinWakeupEnable), .pullLowEnable_n(pullLowEnable_n),
      .pullHighEnable_n(pullHighEnable_n));
   csb_mem_model csb_mem_model_inst (.memAddr(dataMemAddr), .memRdData(dataMemRdData));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic conclude();
      if (num_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge clock);
      regWrite = 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(negedge clock);
      regAddr = a;
      @(negedge clock);
      regRead = 1'b1;
      @(negedge clock);
      regRead = 1'b0;
      chk("read data", {2'b00, regRdData}, {2'b00, exp});
   endtask

   task automatic pc(input csb_pcop_e op, input logic [9:0] t, input logic [9:0] e,
         input logic [10:0] push);
      @(negedge clock);
      pcOp = op;
      instTarget = t;
      @(negedge clock);
      pcOp = CSB_PC_HOLD;
      chk("counter", {1'b0, programCounter}, {1'b0, e});
      chk("push", {returnPush, returnAddr}, push);
      @(negedge clock);
   endtask

   task automatic ev(input logic [2:0] s, input logic [7:0] exp);
      @(negedge clock);
      {sleepExec, clearWatchdogExec, watchdogTimeout} = s;
      @(negedge clock);
      {sleepExec, clearWatchdogExec, watchdogTimeout} = 3'b000;
      rd(ADDR_STATUS, exp);
   endtask

   initial begin
      #(25 * 4000);
      num_errors++;
      conclude();
   end

   initial begin
      {reset, regWrite, regRead, sleepExec, clearWatchdogExec, watchdogTimeout} = 6'h20;
      {regAddr, regWrData, instTarget, portReadbackOption} = '0;
      portPins = 6'h2a;
      portDirIn = 6'h0f;
      pcOp = CSB_PC_HOLD;
      aluFlags = '0;
      repeat (8) @(negedge clock);
      reset = 1'b0;
      for (int i = 0; i < 8; i++) rd(ta[i], tr[i]);
      for (int i = 0; i < 8; i++) wr(ta[i], 8'hff);
      for (int i = 0; i < 8; i++) rd(ta[i], t1[i]);
      chk("pins", {watchdogEnable, extIrqPinSelect, lowVoltageResetEnable, pinWakeupEnable},
         11'h1ff);
      chk("pulls", {pullLowEnable_n, pullHighEnable_n}, 10'h3ff);
      for (int i = 0; i < 8; i++) wr(ta[i], 8'h00);
      for (int i = 0; i < 8; i++) rd(ta[i], t0[i]);
      chk("pins", {watchdogEnable, extIrqPinSelect, lowVoltageResetEnable, pinWakeupEnable},
         10'h000);
      chk("pulls", {pullLowEnable_n, pullHighEnable_n}, 10'h008);
      wr(ADDR_PWR, 8'h40);
      chk("irq pin", {watchdogEnable, extIrqPinSelect, lowVoltageResetEnable}, 10'h002);
      ev(3'b100, 8'h10);
      ev(3'b001, 8'h00);
      ev(3'b010, 8'h18);
      @(negedge clock);
      aluFlags = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      @(negedge clock);
      aluFlags = '0;
      rd(ADDR_STATUS, 8'h1d);
      wr(ADDR_PCHB, 8'h03);
      pc(CSB_PC_JUMP, 10'h1ab, 10'h3ab, 11'h000);
      pc(CSB_PC_CALL, 10'h055, 10'h355, 11'h7ac);
      pc(CSB_PC_LJUMP, 10'h0f0, 10'h0f0, 11'h3ac);
      pc(CSB_PC_LONG_CALL, 10'h123, 10'h123, 11'h4f1);
      pc(CSB_PC_STEP, 10'h000, 10'h124, 11'h0f1);
      wr(ADDR_PCL, 8'h40);
      chk("counter", programCounter, 10'h140);
      wr(ADDR_PORT, 8'hc5);
      chk("latch", {2'b00, portLatch}, 10'h0c5);
      portReadbackOption = 1'b1;
      rd(ADDR_PORT, 8'hca);
      portReadbackOption = 1'b0;
      rd(ADDR_PORT, 8'hea);
      rd(6'h10, 8'h90);
      wr(ADDR_FSP, 8'hd5);
      rd(ADDR_INDIRECT, 8'h95);
      chk("pointer", {4'h0, dataMemAddr}, 10'h015);
      conclude();
   end
endmodule
